// ==== acg_config.sv ====
// Purpose: Conversion start delay and amplifier gain registers with the converter restart sequencer.
// Assumes: Register port driven by the serial command decoder; osr_value comes from the configuration logic.
// Notes: The modulator clock is a one-cycle enable divided from core_clk.
//
// What this block does
// - Any write to the delay register resets the converter, then restarts conversion.
// - Delay register bits 23 to 12 ignore writes and read zero.
// - Delay register holds a 12-bit read/write delay code, zero after reset.
// - Conversion start waits delay code plus half the OSR plus one modulator periods.
// - Gain register at 0x0B holds a 3-bit gain select; upper bits read zero.
`timescale 1ns/1ns
`default_nettype none
module acg_config
  import acg_pkg::*;
#(
  parameter int MOD_DIV = acg_pkg::MOD_DIV_DEFAULT
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [acg_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [acg_pkg::REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic reg_hit,
  output logic [acg_pkg::REG_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [acg_pkg::OSR_W-1:0] osr_value,
  output logic modulator_clock_tick,
  output logic [acg_pkg::DELAY_W-1:0] conversion_delay,
  output logic [acg_pkg::GAIN_SEL_W-1:0] amp_gain_select,
  output logic converter_reset,
  output logic conversion_start,
  output logic converter_running
);

  localparam int DIV_W = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_DIV - 1);
  localparam int RST_W = $clog2(CONV_RESET_CYCLES + 1);
  localparam logic [RST_W-1:0] RST_LAST = RST_W'(CONV_RESET_CYCLES - 1);

  logic [DIV_W-1:0] div_q;
  logic tick_q;
  logic [DELAY_W-1:0] delay_q;
  logic [GAIN_SEL_W-1:0] gain_q;
  logic [REG_DATA_W-1:0] rdata_q;
  logic rvalid_q;
  logic restart_q;
  logic [RST_W-1:0] rst_cnt_q;
  acg_state_type state_q;
  acg_state_type state_d;
  logic delay_wr;
  logic gain_wr;
  logic delay_load;
  logic delay_done;
  logic delay_busy;
  logic [DELAY_CNT_W-1:0] delay_total;

  // ==========================================================================
  // Modulator clock enable
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == DIV_LAST);
      if (div_q == DIV_LAST) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Register decode and storage
  // ==========================================================================
  assign delay_wr = reg_wr && (reg_addr == ADDR_CONV_START_DELAY);
  assign gain_wr = reg_wr && (reg_addr == ADDR_AMPLIFIER_GAIN_CONFIG);
  assign reg_hit = (reg_addr == ADDR_CONV_START_DELAY) || (reg_addr == ADDR_AMPLIFIER_GAIN_CONFIG);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      delay_q <= DELAY_RESET;
    end else if (delay_wr) begin
      delay_q <= reg_wdata[DELAY_LSB +: DELAY_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gain_q <= GAIN_SEL_RESET;
    end else if (gain_wr) begin
      gain_q <= reg_wdata[GAIN_SEL_LSB +: GAIN_SEL_W];
    end
  end

  // Read answer one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= '0;
        if (reg_addr == ADDR_CONV_START_DELAY) begin
          rdata_q[DELAY_LSB +: DELAY_W] <= delay_q;
        end else if (reg_addr == ADDR_AMPLIFIER_GAIN_CONFIG) begin
          rdata_q[GAIN_SEL_LSB +: GAIN_SEL_W] <= gain_q;
        end
      end
    end
  end

  // ==========================================================================
  // Restart sequencer
  // ==========================================================================
  // A delay register write during any phase restarts the whole sequence
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      restart_q <= 1'b1;
    end else begin
      restart_q <= delay_wr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_cnt_q <= '0;
    end else if (restart_q || state_q != ST_RESET) begin
      rst_cnt_q <= '0;
    end else if (rst_cnt_q != RST_LAST) begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        state_d = ST_IDLE;
      end
      ST_RESET: begin
        if (rst_cnt_q == RST_LAST) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (delay_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (restart_q) begin
      state_d = ST_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Start delay: code plus half the oversampling ratio
  // ==========================================================================
  assign delay_total = DELAY_CNT_W'(delay_q) + DELAY_CNT_W'(osr_value[OSR_W-1:1]);
  assign delay_load = (state_q == ST_RESET) && (rst_cnt_q == RST_LAST) && !restart_q;

  acg_start_delay #(
    .CNT_W(DELAY_CNT_W)
  ) u_start_delay (
    .core_clk(core_clk),
    .sys_rst(sys_rst || restart_q),
    .load(delay_load),
    .load_value(delay_total),
    .mod_tick(tick_q),
    .busy(delay_busy),
    .done(delay_done)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic start_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= (state_q == ST_WAIT) && delay_done && !restart_q;
    end
  end

  assign modulator_clock_tick = tick_q;
  assign conversion_delay = delay_q;
  assign amp_gain_select = gain_q;
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign converter_reset = (state_q == ST_RESET);
  assign conversion_start = start_q;
  assign converter_running = (state_q == ST_RUN);

endmodule : acg_config
`default_nettype wire

// ==== acg_pkg.sv ====
// Purpose: Shared constants for the converter phase and gain configuration block.
// Assumes: 24-bit registers reached by 5-bit register addresses from the serial command decoder.
// Notes: Offsets are register addresses, not byte addresses.
package acg_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int REG_ADDR_W = 5;
  localparam int REG_DATA_W = 24;
  localparam logic [4:0] ADDR_CONV_START_DELAY = 5'h0a;
  localparam logic [4:0] ADDR_AMPLIFIER_GAIN_CONFIG = 5'h0b;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int DELAY_W = 12;
  localparam int DELAY_LSB = 0;
  localparam int GAIN_SEL_W = 3;
  localparam int GAIN_SEL_LSB = 0;
  localparam logic [11:0] DELAY_RESET = 12'h000;
  localparam logic [2:0] GAIN_SEL_RESET = 3'h0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int OSR_W = 13;
  localparam int DELAY_CNT_W = 14;
  localparam int MOD_DIV_DEFAULT = 4;
  localparam int CONV_RESET_CYCLES = 2;

  // ==========================================================================
  // Restart sequencer states
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RESET = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_RUN = 4'b1000
  } acg_state_type;

endpackage : acg_pkg

// ==== acg_start_delay.sv ====
// Purpose: Counts a start delay in modulator clock periods.
// Assumes: mod_tick is a one-cycle enable at the modulator clock rate.
// Notes: A load restarts the count; done pulses once when it expires.
`timescale 1ns/1ns
`default_nettype none
module acg_start_delay
  import acg_pkg::*;
#(
  parameter int CNT_W = acg_pkg::DELAY_CNT_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic mod_tick,
  output logic busy,
  output logic done
);

  logic [CNT_W-1:0] count_q;
  logic busy_q;
  logic done_q;

  // ==========================================================================
  // Period counter
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load) begin
        count_q <= load_value;
        busy_q <= 1'b1;
      end else if (busy_q && mod_tick) begin
        if (count_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule : acg_start_delay
`default_nettype wire

// ==== acg_config_asserts.sv ====
// Purpose: Port checks for acg_config.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every acg_config instance.
`timescale 1ns/1ns
`default_nettype none
module acg_config_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [acg_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [acg_pkg::REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [acg_pkg::REG_DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [acg_pkg::DELAY_W-1:0] conversion_delay,
  input wire logic [acg_pkg::GAIN_SEL_W-1:0] amp_gain_select,
  input wire logic converter_reset,
  input wire logic conversion_start,
  input wire logic converter_running
);
  import acg_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // A delay write during reset or in the cycle before the start pulse legally restarts the sequence
  logic dly_wr;
  assign dly_wr = reg_wr && reg_addr == ADDR_CONV_START_DELAY;
  // ==========================================================================
  // Register port
  property p_rd_lat; reg_rd |=> reg_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
  property p_rd_quiet; !reg_rd |=> !reg_rvalid; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read answer");
  property p_dly_rd;
    reg_rd && !reg_wr && reg_addr == ADDR_CONV_START_DELAY |=> reg_rdata == {12'h000, conversion_delay};
  endproperty
  a_dly_rd: assert property (p_dly_rd) else $error("delay read wrong");
  property p_gain_rd;
    reg_rd && !reg_wr && reg_addr == ADDR_AMPLIFIER_GAIN_CONFIG |=> reg_rdata == {21'h0, amp_gain_select};
  endproperty
  a_gain_rd: assert property (p_gain_rd) else $error("gain read wrong");
  property p_dly_wr;
    reg_wr && reg_addr == ADDR_CONV_START_DELAY |=> {12'h000, conversion_delay} == ($past(reg_wdata) & 24'h000fff);
  endproperty
  a_dly_wr: assert property (p_dly_wr) else $error("delay write lost");
  property p_gain_wr;
    reg_wr && reg_addr == ADDR_AMPLIFIER_GAIN_CONFIG |=> {21'h0, amp_gain_select} == ($past(reg_wdata) & 24'h000007);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");
  // ==========================================================================
  // Restart sequence
  property p_restart; reg_wr && reg_addr == ADDR_CONV_START_DELAY |-> ##2 converter_reset && !converter_running; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_rst_len;
    $rose(converter_reset) && !dly_wr && !$past(dly_wr) |-> converter_reset [*2] ##1 !converter_reset;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset length wrong");
  property p_start;
    conversion_start && !$past(dly_wr) |-> !converter_reset ##1 !conversion_start && converter_running;
  endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");
  c_start: cover property (conversion_start);
  c_restart: cover property ($rose(converter_reset));
  c_read: cover property (reg_rvalid);
endmodule : acg_config_asserts
bind acg_config acg_config_asserts u_acg_config_asserts (.core_clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rd, .reg_rdata, .reg_rvalid, .conversion_delay, .amp_gain_select, .converter_reset, .conversion_start,
  .converter_running);
`default_nettype wire

// ==== test_acg_config.sv ====
// Purpose: Register and restart tests for acg_config.
// Assumes: Modulator tick every 2 core_clk cycles.
// Notes: Start delay is counted in modulator ticks.
`timescale 1ns/1ns
`default_nettype none
module test_acg_config;
  import acg_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [23:0] reg_wdata = 24'h000000;
  logic [12:0] osr_value = 13'h0020;
  logic reg_hit, reg_rvalid, modulator_clock_tick, converter_reset, conversion_start, converter_running;
  logic [23:0] reg_rdata;
  logic [11:0] conversion_delay;
  logic [2:0] amp_gain_select;
  int num_errors = 0;
  int n_checks = 0;
  always #10 core_clk = ~core_clk;
  acg_config #(.MOD_DIV(2)) u_acg_config (.core_clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_hit, .reg_rdata, .reg_rvalid, .osr_value, .modulator_clock_tick, .conversion_delay,
    .amp_gain_select, .converter_reset, .conversion_start, .converter_running);
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [23:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk({23'h0, reg_rvalid}, 24'h000001);
    chk(reg_rdata, e);
    chk({23'h0, reg_hit}, {23'h0, a == ADDR_CONV_START_DELAY || a == ADDR_AMPLIFIER_GAIN_CONFIG});
  endtask : rd
  // Ticks from end of converter reset to the start pulse
  task automatic meas(input logic [11:0] d, input logic [12:0] osr);
    int n;
    int k;
    int e;
    n = 0;
    k = 0;
    e = d + osr / 2 + 1;
    osr_value <= osr;
    wr(ADDR_CONV_START_DELAY, {12'hfff, d});
    while (converter_reset !== 1'b1 && k < 8) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk({23'h0, converter_reset}, 24'h000001);
    while (converter_reset === 1'b1 && k < 16) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    while (conversion_start !== 1'b1 && k < 20000) begin
      @(posedge core_clk);
      #1;
      if (modulator_clock_tick === 1'b1) n++;
      k++;
    end
    chk({23'h0, n >= e && n <= e + 1}, 24'h000001);
    chk({23'h0, converter_running}, 24'h000001);
    rd(ADDR_CONV_START_DELAY, {12'h000, d});
    chk({12'h000, conversion_delay}, {12'h000, d});
  endtask : meas
  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================================
  // Tests
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(ADDR_CONV_START_DELAY, 24'h000000);
    rd(ADDR_AMPLIFIER_GAIN_CONFIG, 24'h000000);
    rd(5'h0c, 24'h000000);
    wr(ADDR_AMPLIFIER_GAIN_CONFIG, 24'hfffffd);
    rd(ADDR_AMPLIFIER_GAIN_CONFIG, 24'h000005);
    chk({21'h0, amp_gain_select}, 24'h000005);
    wr(5'h0c, 24'h123456);
    rd(ADDR_AMPLIFIER_GAIN_CONFIG, 24'h000005);
    meas(12'h003, 13'h0020);
    meas(12'hfff, 13'h0040);
    meas(12'h000, 13'h1000);
    wrap_up();
  end
  initial begin
    #600000;
    num_errors++;
    wrap_up();
  end
endmodule : test_acg_config
`default_nettype wire
